/* core/cach_handler.sv */
`include "cach_regs.svh"

module cach_handler
    import cach_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] DEVICE_ADDR,
    input wire logic STACK_MEMBER_FLAG,
    input wire logic CHAIN_TOP_DEVICE,
    input wire cach_byte_t CMD_IN,
    output cach_byte_t CMD_OUT,
    input wire cach_byte_t RSP_IN,
    output cach_byte_t RSP_OUT,
    output cach_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    output logic CMD_CRC_ERR,
    output logic RSP_CRC_FAULT,
    output logic BUSY
);

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ b[i]) begin
                c = (c >> 1) ^ `CACH_CRC_POLY_REFL;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction : crc_step

    // Command parser state
    logic [3:0] cidx_ff;
    logic [7:0] chdr_ff;
    logic [7:0] cdev_ff;
    logic [15:0] creg_ff;
    logic [7:0] ccnt_ff;
    logic [15:0] ccrc_ff;
    logic [7:0] wbuf_ff [`CACH_MAX_WRITE_REGS];

    logic [7:0] hdr;
    logic [2:0] req;
    logic has_dev;
    logic [3:0] data_pos;
    logic [3:0] ndata;
    logic [3:0] clen;
    logic clast;
    logic [15:0] nxt_ccrc;
    logic cmd_good;
    logic dev_match;
    logic start_rd;
    logic start_stack;
    logic start_wr;

    always_comb begin
        hdr = (cidx_ff == 4'h0) ? CMD_IN.data : chdr_ff;
        req = hdr[`CACH_HDR_REQ_HI:`CACH_HDR_REQ_LO];
        // no address byte for stack frames
        has_dev = (req == `CACH_REQ_SINGLE_READ) || (req == `CACH_REQ_SINGLE_WRITE);
        data_pos = has_dev ? 4'h4 : 4'h3;
        // count field is registers minus one
        ndata = req[0] ? ({1'b0, hdr[`CACH_HDR_SIZE_HI:`CACH_HDR_SIZE_LO]} + 4'h1) : 4'h1;
        clen = data_pos + ndata + `CACH_CMD_TAIL_BYTES;
        clast = CMD_IN.valid && (cidx_ff == clen - 4'h1);
        nxt_ccrc = crc_step((cidx_ff == 4'h0) ? `CACH_CRC_INIT : ccrc_ff, CMD_IN.data);
        cmd_good = clast && (nxt_ccrc == `CACH_CRC_GOOD) && hdr[`CACH_HDR_KIND_BIT];
        dev_match = (cdev_ff == DEVICE_ADDR);
        start_rd = cmd_good && (req == `CACH_REQ_SINGLE_READ) && dev_match;
        start_wr = cmd_good && (req == `CACH_REQ_SINGLE_WRITE) && dev_match;
        start_stack = cmd_good && (req == `CACH_REQ_STACK_READ) && STACK_MEMBER_FLAG;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            cidx_ff <= 4'h0;
            chdr_ff <= 8'h00;
            cdev_ff <= 8'h00;
            creg_ff <= 16'h0000;
            ccnt_ff <= 8'h00;
            ccrc_ff <= `CACH_CRC_INIT;
        end else if (CMD_IN.valid) begin
            cidx_ff <= clast ? 4'h0 : cidx_ff + 4'h1;
            ccrc_ff <= nxt_ccrc;
            if (cidx_ff == 4'h0) begin
                chdr_ff <= CMD_IN.data;
            end
            if (has_dev && cidx_ff == 4'h1) begin
                cdev_ff <= CMD_IN.data;
            end
            if (cidx_ff == data_pos - 4'h2) begin
                creg_ff[15:8] <= CMD_IN.data;
            end
            if (cidx_ff == data_pos - 4'h1) begin
                creg_ff[7:0] <= CMD_IN.data;
            end
            if (cidx_ff == data_pos) begin
                ccnt_ff <= CMD_IN.data;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (CMD_IN.valid && cidx_ff >= data_pos && cidx_ff < data_pos + ndata) begin
            wbuf_ff[3'(cidx_ff - data_pos)] <= CMD_IN.data;
        end
    end

    // command relayed whether good or not
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CMD_OUT <= '0;
            CMD_CRC_ERR <= 1'b0;
        end else begin
            CMD_OUT <= CMD_IN;
            CMD_CRC_ERR <= clast && (nxt_ccrc != `CACH_CRC_GOOD);
        end
    end

    // Write execution
    logic wr_act_ff;
    logic [2:0] wr_idx_ff;
    logic [2:0] wr_last_ff;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            wr_act_ff <= 1'b0;
            wr_idx_ff <= 3'h0;
            wr_last_ff <= 3'h0;
        end else if (start_wr) begin
            wr_act_ff <= 1'b1;
            wr_idx_ff <= 3'h0;
            wr_last_ff <= hdr[`CACH_HDR_SIZE_HI:`CACH_HDR_SIZE_LO];
        end else if (wr_act_ff) begin
            wr_idx_ff <= wr_idx_ff + 3'h1;
            wr_act_ff <= (wr_idx_ff != wr_last_ff);
        end
    end

    // Upstream response relay and check
    logic [8:0] uidx_ff;
    logic [8:0] ulen_ff;
    logic [15:0] ucrc_ff;
    logic [15:0] nxt_ucrc;
    logic [8:0] ulen;
    logic ulast;

    always_comb begin
        nxt_ucrc = crc_step((uidx_ff == 9'h000) ? `CACH_CRC_INIT : ucrc_ff, RSP_IN.data);
        ulen = (uidx_ff == 9'h000) ? ({1'b0, RSP_IN.data} + 9'h001 + `CACH_RSP_PROTO_BYTES) : ulen_ff;
        ulast = RSP_IN.valid && (uidx_ff == ulen - 9'h001);
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            uidx_ff <= 9'h000;
            ulen_ff <= 9'h000;
            ucrc_ff <= `CACH_CRC_INIT;
        end else if (RSP_IN.valid) begin
            uidx_ff <= ulast ? 9'h000 : uidx_ff + 9'h001;
            ulen_ff <= ulen;
            ucrc_ff <= nxt_ucrc;
        end
    end

    // Own response generator
    cach_rsp_state_t rsp_state_ff;
    logic [8:0] ridx_ff;
    logic [8:0] rcnt_ff;
    logic [15:0] rbase_ff;
    logic [15:0] rcrc_ff;
    logic [7:0] rbyte;
    logic rsend;
    logic rdone;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rsp_state_ff <= CACH_RSP_IDLE;
            RSP_CRC_FAULT <= 1'b0;
        end else begin
            RSP_CRC_FAULT <= 1'b0;
            unique case (rsp_state_ff)
                CACH_RSP_IDLE: begin
                    if (start_rd) begin
                        rsp_state_ff <= CACH_RSP_SEND;
                    end else if (start_stack && CHAIN_TOP_DEVICE) begin
                        rsp_state_ff <= CACH_RSP_SEND;
                    end else if (start_stack) begin
                        rsp_state_ff <= CACH_RSP_WAIT;
                    end
                end
                CACH_RSP_WAIT: begin
                    if (ulast && nxt_ucrc == `CACH_CRC_GOOD) begin
                        rsp_state_ff <= CACH_RSP_SEND;
                    end else if (ulast) begin
                        rsp_state_ff <= CACH_RSP_IDLE;
                        RSP_CRC_FAULT <= 1'b1;
                    end
                end
                CACH_RSP_SEND: begin
                    if (rdone) begin
                        rsp_state_ff <= CACH_RSP_IDLE;
                    end
                end
            endcase
        end
    end

    assign rsend = (rsp_state_ff == CACH_RSP_SEND);
    assign rdone = rsend && (ridx_ff == rcnt_ff + `CACH_RSP_PROTO_BYTES - 9'h001);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rcnt_ff <= 9'h000;
            rbase_ff <= 16'h0000;
        end else if (start_rd || start_stack) begin
            rcnt_ff <= {1'b0, ccnt_ff} + 9'h001;
            rbase_ff <= creg_ff;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ridx_ff <= 9'h000;
            rcrc_ff <= `CACH_CRC_INIT;
        end else if (rsend) begin
            ridx_ff <= rdone ? 9'h000 : ridx_ff + 9'h001;
            if (ridx_ff < rcnt_ff + 9'h004) begin
                rcrc_ff <= crc_step(rcrc_ff, rbyte);
            end
        end else begin
            ridx_ff <= 9'h000;
            rcrc_ff <= `CACH_CRC_INIT;
        end
    end

    always_comb begin
        if (ridx_ff == 9'h000) begin
            rbyte = ccnt_ff;
        end else if (ridx_ff == 9'h001) begin
            rbyte = DEVICE_ADDR;
        end else if (ridx_ff == 9'h002) begin
            rbyte = rbase_ff[15:8];
        end else if (ridx_ff == 9'h003) begin
            rbyte = rbase_ff[7:0];
        end else if (ridx_ff < rcnt_ff + 9'h004) begin
            rbyte = REG_RDATA;
        end else if (ridx_ff == rcnt_ff + 9'h004) begin
            rbyte = rcrc_ff[7:0];
        end else begin
            rbyte = rcrc_ff[15:8];
        end
    end

    // Response output: relay has priority, own frame only when upstream idle
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            RSP_OUT <= '0;
        end else if (RSP_IN.valid) begin
            RSP_OUT <= RSP_IN;
        end else begin
            RSP_OUT.valid <= rsend;
            RSP_OUT.data <= rsend ? rbyte : 8'h00;
        end
    end

    // Register port: one write per cycle, reads one cycle ahead
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            REG_REQ <= '0;
        end else if (wr_act_ff) begin
            REG_REQ.wr_en <= 1'b1;
            REG_REQ.rd_en <= 1'b0;
            REG_REQ.addr <= creg_ff + {13'h0000, wr_idx_ff};
            REG_REQ.wdata <= wbuf_ff[wr_idx_ff];
        end else begin
            REG_REQ.wr_en <= 1'b0;
            REG_REQ.rd_en <= rsend && (ridx_ff >= 9'h003) && (ridx_ff < rcnt_ff + 9'h003);
            REG_REQ.addr <= rbase_ff + {7'h00, ridx_ff - 9'h003};
            REG_REQ.wdata <= 8'h00;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            BUSY <= 1'b0;
        end else begin
            BUSY <= wr_act_ff || (rsp_state_ff != CACH_RSP_IDLE) || (cidx_ff != 4'h0);
        end
    end

endmodule : cach_handler

/* core/cach_pkg.sv */
package cach_pkg;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } cach_byte_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cach_reg_req_t;

    typedef enum logic [1:0] {
        CACH_RSP_IDLE = 2'b00,
        CACH_RSP_WAIT = 2'b01,
        CACH_RSP_SEND = 2'b11
    } cach_rsp_state_t;

endpackage : cach_pkg

/* core/cach_regs.svh */
`ifndef CACH_REGS_SVH
`define CACH_REGS_SVH

// Header byte fields
`define CACH_HDR_KIND_BIT 7
`define CACH_HDR_REQ_HI 6
`define CACH_HDR_REQ_LO 4
`define CACH_HDR_SIZE_HI 2
`define CACH_HDR_SIZE_LO 0

// Request codes
`define CACH_REQ_SINGLE_READ 3'h0
`define CACH_REQ_SINGLE_WRITE 3'h1
`define CACH_REQ_STACK_READ 3'h2

// CRC-16 over LSB-first bit stream, reflected polynomial form
`define CACH_CRC_INIT 16'hffff
`define CACH_CRC_POLY_REFL 16'ha001
`define CACH_CRC_GOOD 16'h0000

// Frame sizes
`define CACH_RSP_PROTO_BYTES 9'h006
`define CACH_CMD_TAIL_BYTES 4'h2
`define CACH_MAX_WRITE_REGS 8

`endif

/* test/cach_far_model.sv */
module cach_far_model
    import cach_pkg::*;
(
    input wire logic CLK_SYS,
    input wire cach_reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output cach_byte_t RSP_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    initial begin
        RSP_IN = '0;
        foreach (mem[a]) mem[a] = 8'(a) ^ 8'h3c;
    end
    assign REG_RDATA = mem[REG_REQ.addr];
    always @(posedge CLK_SYS) begin
        if (REG_REQ.wr_en) mem[REG_REQ.addr] <= REG_REQ.wdata;
    end
    task send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            RSP_IN <= {1'b1, q[i]};
            @(posedge CLK_SYS);
        end
        RSP_IN <= {1'b0, ~q[q.size()-1]};
    endtask : send
endmodule : cach_far_model

/* test/cach_handler_properties.sv */
module cach_handler_checker
    import cach_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] DEVICE_ADDR,
    input wire cach_byte_t CMD_IN,
    input wire cach_byte_t CMD_OUT,
    input wire cach_byte_t RSP_IN,
    input wire cach_byte_t RSP_OUT,
    input wire cach_reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic CMD_CRC_ERR,
    input wire logic RSP_CRC_FAULT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_cmd_relay; CMD_IN.valid |=> CMD_OUT == $past(CMD_IN); endproperty
    a_cmd_relay: assert property (p_cmd_relay) else $error("command byte not relayed");
    property p_rsp_relay; RSP_IN.valid |=> RSP_OUT == $past(RSP_IN); endproperty
    a_rsp_relay: assert property (p_rsp_relay) else $error("upstream byte not relayed");
    property p_rd_data; REG_REQ.rd_en |=> RSP_OUT.valid && RSP_OUT.data == $past(REG_RDATA); endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data not sent");
    property p_rd_step; REG_REQ.rd_en ##1 REG_REQ.rd_en |-> REG_REQ.addr == $past(REG_REQ.addr) + 16'h0001; endproperty
    a_rd_step: assert property (p_rd_step) else $error("read address not consecutive");
    property p_wr_step; REG_REQ.wr_en ##1 REG_REQ.wr_en |-> REG_REQ.addr == $past(REG_REQ.addr) + 16'h0001; endproperty
    a_wr_step: assert property (p_wr_step) else $error("write address not consecutive");
    property p_own_addr; $rose(REG_REQ.rd_en) |-> $past(RSP_OUT.valid, 2) && $past(RSP_OUT.data, 2) == DEVICE_ADDR; endproperty
    a_own_addr: assert property (p_own_addr) else $error("own address missing");
    property p_crc_drop; CMD_CRC_ERR |-> (!REG_REQ.wr_en && !REG_REQ.rd_en) [*8]; endproperty
    a_crc_drop: assert property (p_crc_drop) else $error("bad frame executed");
    property p_fault; RSP_CRC_FAULT |=> (!RSP_CRC_FAULT && !REG_REQ.rd_en) [*8]; endproperty
    a_fault: assert property (p_fault) else $error("answer after upstream fault");
    c_wr: cover property (REG_REQ.wr_en);
    c_rd: cover property ($rose(REG_REQ.rd_en));
    c_crc: cover property (CMD_CRC_ERR);
    c_flt: cover property (RSP_CRC_FAULT);
endmodule : cach_handler_checker

bind cach_handler cach_handler_checker u_chk (.*);

/* test/tb.sv */
`define CHK(a, b, m) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        n_fail++; \
        $display("unexpected %0t %s", $time, m); \
    end \
end
module tb
    import cach_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] dev_addr = 8'h02;
    logic member = 1'b1;
    logic top = 1'b1;
    cach_byte_t cmd_in = '0;
    cach_byte_t cmd_q = '0;
    cach_byte_t cmd_out;
    cach_byte_t rsp_in, rsp_out;
    cach_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic crc_err, flt, busy;
    int n_fail = 0;
    int total_checks = 0;
    int n_err = 0;
    int n_flt = 0;
    logic [7:0] c[$], e[$], u[$], got[$];
    cach_handler dut (
        .CLK_SYS(clk), .RST(rst), .DEVICE_ADDR(dev_addr), .STACK_MEMBER_FLAG(member),
        .CHAIN_TOP_DEVICE(top), .CMD_IN(cmd_in), .CMD_OUT(cmd_out), .RSP_IN(rsp_in), .RSP_OUT(rsp_out),
        .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .CMD_CRC_ERR(crc_err), .RSP_CRC_FAULT(flt), .BUSY(busy)
    );
    cach_far_model far (.CLK_SYS(clk), .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .RSP_IN(rsp_in));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rsp_out.valid === 1'b1) got.push_back(rsp_out.data);
        n_err += crc_err;
        n_flt += flt;
        if (cmd_q.valid === 1'b1) `CHK(cmd_out, cmd_q, "command relay")
        cmd_q = cmd_in;
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] r;
        r = 16'hffff;
        foreach (q[i]) begin
            r ^= {8'h00, q[i]};
            repeat (8) r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
        end
        return r;
    endfunction : crc16
    task automatic seal(ref logic [7:0] q[$]);
        logic [15:0] r;
        r = crc16(q);
        q.push_back(r[7:0]);
        q.push_back(r[15:8]);
    endtask : seal
    function automatic logic [7:0] ed(input logic [15:0] a);
        return (a >= 16'h0300 && a < 16'h0308) ? 8'hc0 + a[7:0] : a[7:0] ^ 8'h3c;
    endfunction : ed
    // Expected answer frame
    task automatic frame(input logic [7:0] dev, input logic [15:0] r, input logic [7:0] n);
        logic [7:0] f[$];
        f = {n, dev, r[15:8], r[7:0]};
        for (int i = 0; i <= n; i++) f.push_back(ed(r + 16'(i)));
        seal(f);
        e = {e, f};
    endtask : frame
    task automatic send(input bit bad);
        seal(c);
        if (bad) c[c.size()-1] ^= 8'h01;
        foreach (c[i]) begin
            cmd_in <= {1'b1, c[i]};
            @(posedge clk);
        end
        cmd_in <= '0;
    endtask : send
    task automatic settle();
        int k;
        k = 0;
        repeat (4) @(posedge clk);
        while (busy !== 1'b0 && k < 400) begin
            @(posedge clk);
            k++;
        end
        if (k == 400) begin
            n_fail++;
            $display("unexpected %0t busy stuck", $time);
            summarize();
        end
        repeat (4) @(posedge clk);
    endtask : settle
    task automatic match();
        `CHK(got.size(), e.size(), "frame length")
        foreach (e[i]) if (i < got.size()) `CHK(got[i], e[i], "frame byte")
        got.delete();
        e.delete();
        c.delete();
    endtask : match
    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        c = {8'h97, 8'h02, 8'h03, 8'h00};
        for (int i = 0; i < 8; i++) c.push_back(8'hc0 + 8'(i));
        send(0);
        settle();
        c = {8'h90, 8'h05, 8'h03, 8'h00, 8'h11};
        send(0);
        settle();
        c = {8'h90, 8'h02, 8'h03, 8'h01, 8'h22};
        send(1);
        settle();
        `CHK(n_err, 1, "crc error count")
        frame(8'h02, 16'h02fc, 8'h1f);
        c = {8'h80, 8'h02, 8'h02, 8'hfc, 8'h1f};
        send(0);
        settle();
        match();
        c = {8'h80, 8'h05, 8'h02, 8'hfc, 8'h1f};
        send(0);
        settle();
        match();
        frame(8'h02, 16'h0010, 8'h03);
        c = {8'ha0, 8'h00, 8'h10, 8'h03};
        send(0);
        settle();
        match();
        top <= 1'b0;
        frame(8'h03, 16'h0010, 8'h03);
        u = e;
        frame(8'h02, 16'h0010, 8'h03);
        c = {8'ha0, 8'h00, 8'h10, 8'h03};
        send(0);
        far.send(u);
        settle();
        match();
        frame(8'h03, 16'h0010, 8'h03);
        e[e.size()-1] ^= 8'h01;
        u = e;
        c = {8'ha0, 8'h00, 8'h10, 8'h03};
        send(0);
        far.send(u);
        settle();
        match();
        `CHK(n_flt, 1, "upstream fault count")
        member <= 1'b0;
        c = {8'ha0, 8'h00, 8'h10, 8'h03};
        send(0);
        settle();
        match();
        summarize();
    end
endmodule : tb
